//--- src/frc_pkg.sv
// Purpose: Shared constants and types of the frequency reference combiner
// Assumes: Frequencies in 0.01 Hz, switching frequency in 0.1 kHz
// Notes: Register byte address is four times the register index
package frc_pkg;
   // Register indices
   localparam logic [15:0] IDX_AUX_BASE = 16'hF005;
   localparam logic [15:0] IDX_AUX_PCT = 16'hF006;
   localparam logic [15:0] IDX_SUPERPOS = 16'hF007;
   localparam logic [15:0] IDX_PRESET = 16'hF008;
   localparam logic [15:0] IDX_DIR = 16'hF009;
   localparam logic [15:0] IDX_MAXF = 16'hF00A;
   localparam logic [15:0] IDX_ULIM_SEL = 16'hF00B;
   localparam logic [15:0] IDX_ULIM = 16'hF00C;
   localparam logic [15:0] IDX_ULIM_OFS = 16'hF00D;
   localparam logic [15:0] IDX_LLIM = 16'hF00E;
   localparam logic [15:0] IDX_SWF = 16'hF00F;
   localparam logic [15:0] IDX_THERM = 16'hF010;
   localparam logic [15:0] IDX_T_UP = 16'hF011;
   localparam logic [15:0] IDX_T_DN = 16'hF012;
   localparam logic [15:0] IDX_T_UNIT = 16'hF013;
   localparam logic [15:0] IDX_RAMP_BASE = 16'hF019;
   localparam logic [15:0] IDX_DI2_FUNC = 16'hF401;
   localparam logic [15:0] IDX_CTRL = 16'hF0F0;
   localparam logic [15:0] IDX_STATUS = 16'hF0F1;
   // Reset values
   localparam logic [15:0] RST_AUX_PCT = 16'h0064;
   localparam logic [15:0] RST_PRESET = 16'h1388;
   localparam logic [15:0] RST_MAXF = 16'h1388;
   localparam logic [15:0] RST_ULIM = 16'h1388;
   localparam logic [15:0] RST_SWF = 16'h003C;
   localparam logic [15:0] RST_THERM = 16'h0001;
   localparam logic [15:0] RST_T_RAMP = 16'h00C8;
   localparam logic [15:0] RST_T_UNIT = 16'h0001;
   // Field ranges
   localparam logic [15:0] FREQ_TOP = 16'hEA60;
   localparam logic [15:0] MAXF_LOW = 16'h1388;
   localparam logic [15:0] PCT_TOP = 16'h0096;
   localparam logic [15:0] SEL_TOP = 16'h002C;
   localparam logic [15:0] SWF_LOW = 16'h0008;
   localparam logic [15:0] SWF_TOP = 16'h0096;
   localparam logic [15:0] TIME_TOP = 16'hFDE8;
   localparam logic [15:0] FIXED_BASE = 16'h2710;
   localparam logic [15:0] DI_FUNC_SWITCH = 16'h0012;
   // Timing
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned RAMP_TICK_MS = 10;
   localparam int unsigned RAMP_TICK_CYC = CLK_HZ / 1000 * RAMP_TICK_MS;
   localparam int unsigned SWF_UNIT_HZ = 100;
   localparam logic [19:0] CARRIER_NUM = 20'(CLK_HZ / SWF_UNIT_HZ);

   typedef enum logic [1:0] {RAMP_HOLD, RAMP_UP, RAMP_DOWN} frc_ramp_t;

   typedef struct packed {
      logic [15:0] freq;
      logic reverse;
      logic [15:0] carrier_period;
      logic running;
   } frc_drive_t;

   typedef struct packed {
      logic [15:0] analog_input_one;
      logic [15:0] analog_input_two;
      logic [15:0] analog_input_three;
      logic [15:0] comm;
      logic [15:0] multi;
   } frc_ulim_src_t;
endpackage : frc_pkg

//--- src/frc_combiner.sv
// Purpose: Frequency reference combiner with limits, ramp and carrier period
// Assumes: APB slave, zero wait states, inputs X and Y on pclk
// Notes: Values in 0.01 Hz; ramp steps every 10 ms tick
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Base 0: aux equals percent, capped at 150, times maximum frequency.
// - Base 1: aux equals percent times main frequency X.
// - Selector holds two decimal digits, source and operation, up to 44.
// - Ones 0: run from main X only.
// - Ones 1: run from combined result chosen by tens digit.
// - Ones 2: switch input picks X or Y.
// - Ones 3: switch input picks X or combined result.
// - Ones 4: switch input picks Y or combined result.
// - Tens 0: result is X plus Y.
// - Tens 1: result is X minus Y.
// - Tens 2 gives larger, tens 3 smaller of X and Y.
// - Tens 4: result is X times Y.
// - Preset frequency 0 to 600 Hz, resets to 50 Hz, always writable.
// - Direction 1 reverses phase sequence; 0 keeps default.
// - Output never above maximum; maximum 50 to 600 Hz, set only stopped.
// - Upper limit source: register, analog one to three, comm, multi-speed.
// - Running frequency capped by upper limit; register resets to 50 Hz.
// - Offset added to upper limit when it comes from analog input.
// - Raised to lower limit unless upper limit or maximum is lower; lower limit 0 to 600 Hz, resets to zero.
// - Switching period from carrier setting 0.8 to 15 kHz, reset 6 kHz.
// - Thermal adjust 1 lets carrier follow temperature; 0 keeps it fixed.
// - Rise from zero to ramp base takes acceleration time.
// - Fall from ramp base to zero takes deceleration time.
// - Ramp base: maximum, frequency reference, or fixed 100 Hz.
// - Ramp time unit: 1 s, 0.1 s or 0.01 s.
module frc_combiner #(
   parameter int unsigned TICK_CYC = frc_pkg::RAMP_TICK_CYC
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Frequency sources on pclk
   input wire logic [15:0] main_freq_x,
   input wire logic [15:0] aux_freq_y,
   input wire frc_pkg::frc_ulim_src_t ulim_src,
   // Pins
   input wire logic digital_input_terminal,
   input wire logic temperature_high,
   // Modulator side
   output frc_pkg::frc_drive_t drive,
   output logic [15:0] preset_freq
);
   logic [15:0] aux_base_reg, aux_pct_reg, superpos_reg, preset_reg, dir_reg;
   logic [15:0] maxf_reg, ulim_sel_reg, ulim_reg, ulim_ofs_reg, llim_reg;
   logic [15:0] swf_reg, therm_reg, t_up_reg, t_dn_reg, t_unit_reg;
   logic [15:0] ramp_base_reg, di_func_reg;
   logic run_reg, tick;
   logic [1:0] di_sync_reg, hot_sync_reg;
   logic [31:0] tick_cnt_reg;
   logic [15:0] out_reg, out_next, period_reg;
   logic [25:0] acc_reg, acc_next;
   frc_pkg::frc_ramp_t ramp_reg, ramp_next;
   logic wr_en, rd_en, hit;
   logic [31:0] rd_val;

   function automatic logic [17:0] baddr(input logic [15:0] idx);
      return {idx, 2'b00};
   endfunction : baddr
   function automatic logic [15:0] sat16(input logic [31:0] v);
      return (v > 32'h0000FFFF) ? 16'hFFFF : v[15:0];
   endfunction : sat16
   function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clip
   function automatic logic [15:0] mn(input logic [15:0] a, input logic [15:0] b);
      return (a < b) ? a : b;
   endfunction : mn
   function automatic logic [15:0] mx(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? a : b;
   endfunction : mx

   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         {di_sync_reg, hot_sync_reg} <= 4'h0;
      else
         {di_sync_reg, hot_sync_reg} <= {di_sync_reg[0], digital_input_terminal,
                                          hot_sync_reg[0], temperature_high};
   end

   // APB decode
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;

   always_comb
   begin
      hit = 1'b1;
      rd_val = 32'h00000000;
      if (paddr == baddr(frc_pkg::IDX_AUX_BASE))
         rd_val = {16'h0000, aux_base_reg};
      else if (paddr == baddr(frc_pkg::IDX_AUX_PCT))
         rd_val = {16'h0000, aux_pct_reg};
      else if (paddr == baddr(frc_pkg::IDX_SUPERPOS))
         rd_val = {16'h0000, superpos_reg};
      else if (paddr == baddr(frc_pkg::IDX_PRESET))
         rd_val = {16'h0000, preset_reg};
      else if (paddr == baddr(frc_pkg::IDX_DIR))
         rd_val = {16'h0000, dir_reg};
      else if (paddr == baddr(frc_pkg::IDX_MAXF))
         rd_val = {16'h0000, maxf_reg};
      else if (paddr == baddr(frc_pkg::IDX_ULIM_SEL))
         rd_val = {16'h0000, ulim_sel_reg};
      else if (paddr == baddr(frc_pkg::IDX_ULIM))
         rd_val = {16'h0000, ulim_reg};
      else if (paddr == baddr(frc_pkg::IDX_ULIM_OFS))
         rd_val = {16'h0000, ulim_ofs_reg};
      else if (paddr == baddr(frc_pkg::IDX_LLIM))
         rd_val = {16'h0000, llim_reg};
      else if (paddr == baddr(frc_pkg::IDX_SWF))
         rd_val = {16'h0000, swf_reg};
      else if (paddr == baddr(frc_pkg::IDX_THERM))
         rd_val = {16'h0000, therm_reg};
      else if (paddr == baddr(frc_pkg::IDX_T_UP))
         rd_val = {16'h0000, t_up_reg};
      else if (paddr == baddr(frc_pkg::IDX_T_DN))
         rd_val = {16'h0000, t_dn_reg};
      else if (paddr == baddr(frc_pkg::IDX_T_UNIT))
         rd_val = {16'h0000, t_unit_reg};
      else if (paddr == baddr(frc_pkg::IDX_RAMP_BASE))
         rd_val = {16'h0000, ramp_base_reg};
      else if (paddr == baddr(frc_pkg::IDX_DI2_FUNC))
         rd_val = {16'h0000, di_func_reg};
      else if (paddr == baddr(frc_pkg::IDX_CTRL))
         rd_val = {31'h00000000, run_reg};
      else if (paddr == baddr(frc_pkg::IDX_STATUS))
         rd_val = {14'h0000, ramp_reg, out_reg};
      else
         hit = 1'b0;
   end

   // Read data captured in the setup cycle, so it is a flop in the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (rd_en)
         prdata <= rd_val;
   end

   // Register writes; values clipped into range, but upper limit source, time unit, ramp base and input function codes kept as written
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         aux_base_reg <= 16'h0000;
         aux_pct_reg <= frc_pkg::RST_AUX_PCT;
         superpos_reg <= 16'h0000;
         preset_reg <= frc_pkg::RST_PRESET;
         dir_reg <= 16'h0000;
         maxf_reg <= frc_pkg::RST_MAXF;
         ulim_sel_reg <= 16'h0000;
         ulim_reg <= frc_pkg::RST_ULIM;
         ulim_ofs_reg <= 16'h0000;
         llim_reg <= 16'h0000;
         swf_reg <= frc_pkg::RST_SWF;
         therm_reg <= frc_pkg::RST_THERM;
         t_up_reg <= frc_pkg::RST_T_RAMP;
         t_dn_reg <= frc_pkg::RST_T_RAMP;
         t_unit_reg <= frc_pkg::RST_T_UNIT;
         ramp_base_reg <= 16'h0000;
         di_func_reg <= 16'h0000;
         run_reg <= 1'b0;
      end
      else if (wr_en)
      begin
         if (paddr == baddr(frc_pkg::IDX_AUX_BASE))
            aux_base_reg <= clip(pwdata[15:0], 16'h0000, 16'h0001);
         else if (paddr == baddr(frc_pkg::IDX_AUX_PCT))
            aux_pct_reg <= clip(pwdata[15:0], 16'h0000, frc_pkg::PCT_TOP);
         else if (paddr == baddr(frc_pkg::IDX_SUPERPOS))
            superpos_reg <= clip(pwdata[15:0], 16'h0000, frc_pkg::SEL_TOP);
         else if (paddr == baddr(frc_pkg::IDX_PRESET))
            preset_reg <= clip(pwdata[15:0], 16'h0000, frc_pkg::FREQ_TOP);
         else if (paddr == baddr(frc_pkg::IDX_DIR))
            dir_reg <= clip(pwdata[15:0], 16'h0000, 16'h0001);
         else if (paddr == baddr(frc_pkg::IDX_MAXF) && !run_reg && out_reg == 16'h0000)
            maxf_reg <= clip(pwdata[15:0], frc_pkg::MAXF_LOW, frc_pkg::FREQ_TOP);
         else if (paddr == baddr(frc_pkg::IDX_ULIM_SEL))
            ulim_sel_reg <= pwdata[15:0];
         else if (paddr == baddr(frc_pkg::IDX_ULIM))
            ulim_reg <= clip(pwdata[15:0], 16'h0000, frc_pkg::FREQ_TOP);
         else if (paddr == baddr(frc_pkg::IDX_ULIM_OFS))
            ulim_ofs_reg <= clip(pwdata[15:0], 16'h0000, frc_pkg::FREQ_TOP);
         else if (paddr == baddr(frc_pkg::IDX_LLIM))
            llim_reg <= clip(pwdata[15:0], 16'h0000, frc_pkg::FREQ_TOP);
         else if (paddr == baddr(frc_pkg::IDX_SWF))
            swf_reg <= clip(pwdata[15:0], frc_pkg::SWF_LOW, frc_pkg::SWF_TOP);
         else if (paddr == baddr(frc_pkg::IDX_THERM))
            therm_reg <= clip(pwdata[15:0], 16'h0000, 16'h0001);
         else if (paddr == baddr(frc_pkg::IDX_T_UP))
            t_up_reg <= clip(pwdata[15:0], 16'h0000, frc_pkg::TIME_TOP);
         else if (paddr == baddr(frc_pkg::IDX_T_DN))
            t_dn_reg <= clip(pwdata[15:0], 16'h0000, frc_pkg::TIME_TOP);
         else if (paddr == baddr(frc_pkg::IDX_T_UNIT))
            t_unit_reg <= pwdata[15:0];
         else if (paddr == baddr(frc_pkg::IDX_RAMP_BASE))
            ramp_base_reg <= pwdata[15:0];
         else if (paddr == baddr(frc_pkg::IDX_DI2_FUNC))
            di_func_reg <= pwdata[15:0];
         else if (paddr == baddr(frc_pkg::IDX_CTRL))
            run_reg <= pwdata[0];
      end
   end

   assign preset_freq = preset_reg;

   // Source combination
   logic [3:0] ones, tens;
   logic [15:0] aux_base, aux_sc, combo, sel_freq, ulim_raw, ulim_eff, ref_freq;
   logic [31:0] prod;
   logic sw_in;

   always_comb
   begin
      ones = 4'(superpos_reg % 16'h000A);
      tens = 4'(superpos_reg / 16'h000A);
      aux_base = maxf_reg;
      if (aux_base_reg == 16'h0001)
         aux_base = main_freq_x;
      aux_sc = sat16(32'(aux_base) * 32'(mn(aux_pct_reg, frc_pkg::PCT_TOP)) / 32'h64);
      prod = 32'(main_freq_x) * 32'(aux_sc) / 32'h2710;
      case (tens)
         4'h1: combo = (main_freq_x > aux_sc) ? main_freq_x - aux_sc : 16'h0000;
         4'h2: combo = mx(main_freq_x, aux_sc);
         4'h3: combo = mn(main_freq_x, aux_sc);
         4'h4: combo = sat16(prod);
         default: combo = sat16(32'(main_freq_x) + 32'(aux_sc));
      endcase
      sw_in = di_sync_reg[1] && (di_func_reg == frc_pkg::DI_FUNC_SWITCH);
      case (ones)
         4'h1: sel_freq = combo;
         4'h2: sel_freq = sw_in ? aux_sc : main_freq_x;
         4'h3: sel_freq = sw_in ? combo : main_freq_x;
         4'h4: sel_freq = sw_in ? combo : aux_sc;
         default: sel_freq = main_freq_x;
      endcase
   end

   // Upper limit source; reserved code 4 falls back to the register
   always_comb
   begin
      case (ulim_sel_reg)
         16'h0001: ulim_raw = ulim_src.analog_input_one;
         16'h0002: ulim_raw = ulim_src.analog_input_two;
         16'h0003: ulim_raw = ulim_src.analog_input_three;
         16'h0005: ulim_raw = ulim_src.comm;
         16'h0006: ulim_raw = ulim_src.multi;
         default: ulim_raw = ulim_reg;
      endcase
      ulim_eff = ulim_raw;
      if (ulim_sel_reg >= 16'h0001 && ulim_sel_reg <= 16'h0003)
         ulim_eff = sat16(32'(ulim_raw) + 32'(ulim_ofs_reg));
      ref_freq = mn(mn(mx(sel_freq, llim_reg), ulim_eff), maxf_reg);
   end

   // Ramp generator
   logic [15:0] target, ramp_base, t_reg_sel;
   logic [23:0] t_ticks;
   logic [25:0] acc_sum;
   logic [15:0] step;

   always_comb
   begin
      target = run_reg ? ref_freq : 16'h0000;
      case (ramp_base_reg)
         16'h0001: ramp_base = ref_freq;
         16'h0002: ramp_base = frc_pkg::FIXED_BASE;
         default: ramp_base = maxf_reg;
      endcase
      t_reg_sel = (target < out_reg) ? t_dn_reg : t_up_reg;
      case (t_unit_reg)
         16'h0000: t_ticks = 24'(t_reg_sel) * 24'h000064;
         16'h0002: t_ticks = 24'(t_reg_sel);
         default: t_ticks = 24'(t_reg_sel) * 24'h00000A;
      endcase
      acc_sum = acc_reg + 26'(ramp_base);
      step = (t_ticks == 24'h000000) ? 16'hFFFF : sat16(32'(acc_sum / 26'(t_ticks)));
      out_next = out_reg;
      acc_next = acc_reg;
      ramp_next = frc_pkg::RAMP_HOLD;
      if (target > out_reg)
         ramp_next = frc_pkg::RAMP_UP;
      else if (target < out_reg)
         ramp_next = frc_pkg::RAMP_DOWN;
      if (ramp_next != ramp_reg)
         acc_next = 26'h0000000;
      else if (tick && ramp_reg != frc_pkg::RAMP_HOLD)
      begin
         acc_next = (t_ticks == 24'h000000) ? 26'h0000000 :
                    acc_sum - 26'(step) * 26'(t_ticks);
         if (ramp_reg == frc_pkg::RAMP_UP)
            out_next = mn(sat16(32'(out_reg) + 32'(step)), target);
         else
            out_next = (out_reg - target > step) ? out_reg - step : target;
      end
   end

   // Ramp tick divider; a long count, so it is a parameter for simulation
   assign tick = (tick_cnt_reg == TICK_CYC - 1);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick_cnt_reg <= 32'h00000000;
      else
         tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_reg <= 16'h0000;
         acc_reg <= 26'h0000000;
         ramp_reg <= frc_pkg::RAMP_HOLD;
      end
      else
      begin
         out_reg <= out_next;
         acc_reg <= acc_next;
         ramp_reg <= ramp_next;
      end
   end

   // Carrier period; hot derating halves the frequency, floored at minimum
   logic [15:0] swf_eff;
   assign swf_eff = (therm_reg[0] && hot_sync_reg[1]) ? mx(swf_reg >> 1, frc_pkg::SWF_LOW) :
                    swf_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         period_reg <= 16'h0000;
      else
         period_reg <= 16'(frc_pkg::CARRIER_NUM / 20'(swf_eff));
   end

   // Drive outputs, all from flops
   // phase order reversal
   assign drive = '{freq: out_reg, reverse: dir_reg[0], carrier_period: period_reg,
                    running: run_reg};
endmodule : frc_combiner

`default_nettype wire

//--- testbench/frc_combiner_sva.sv
// Purpose: Port-level checks of the frequency reference combiner
// Assumes: Zero wait state APB, ramp ticks every TICK_CYC cycles
// Notes: Bound to every frc_combiner instance
`timescale 1ns/100ps
`default_nettype none
module frc_combiner_sva #(
   parameter int unsigned TICK_CYC = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Modulator side
   input wire frc_pkg::frc_drive_t drive,
   input wire logic [15:0] preset_freq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic acc_wr;
   logic [15:0] wlo;
   logic [15:0] prev_freq;
   logic [15:0] since_chg;
   assign acc_wr = psel && penable && pwrite && pready;
   assign wlo = pwdata[15:0];
   // Distance between frequency steps shows whether ticks are honoured
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_freq <= 16'h0000;
         since_chg <= 16'h0000;
      end
      else
      begin
         prev_freq <= drive.freq;
         since_chg <= (drive.freq != prev_freq) ? 16'h0000 : since_chg + 16'h0001;
      end
   end
   a_ready_high: assert property (pready) else $error("pready low");
   a_err_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
   a_rdata_upper: assert property (prdata[31:16] == 16'h0000) else $error("prdata upper set");
   a_freq_cap: assert property (drive.freq <= frc_pkg::FREQ_TOP)
      else $error("frequency above ceiling");
   a_carrier_range: assert property ($past(presetn) |-> drive.carrier_period inside
      {[16'h0A6A:16'hC350]}) else $error("carrier period out of range");
   a_preset_write: assert property (acc_wr &&
      paddr == {frc_pkg::IDX_PRESET, 2'b00} |-> ##2
      preset_freq == (($past(wlo, 2) > frc_pkg::FREQ_TOP) ? frc_pkg::FREQ_TOP : $past(wlo, 2)))
      else $error("preset not taken");
   a_dir_write: assert property (acc_wr && paddr == {frc_pkg::IDX_DIR, 2'b00} |-> ##2
      drive.reverse == $past(wlo[0], 2)) else $error("direction not taken");
   a_step_tick: assert property ($changed(drive.freq) |-> since_chg >= TICK_CYC - 1)
      else $error("frequency stepped between ticks");
   c_run_write: cover property (acc_wr && paddr == {frc_pkg::IDX_CTRL, 2'b00});
   c_unmapped: cover property (pslverr);
   c_step: cover property ($changed(drive.freq));
endmodule : frc_combiner_sva
bind frc_combiner frc_combiner_sva #(.TICK_CYC(TICK_CYC)) u_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive(drive), .preset_freq(preset_freq));
`default_nettype wire

//--- testbench/frc_power_stage.sv
// Purpose: Behavioural power stage fed by the drive bundle
// Assumes: Heating is commanded by the bench
// Notes: Over-temperature flag is a registered copy of the heat command
`timescale 1ns/100ps
`default_nettype none
module frc_power_stage (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Drive bundle and thermal state
   input wire frc_pkg::frc_drive_t drive,
   input wire logic heat_cmd,
   output var logic temperature_high
);
   // Heat sink lags the command by one cycle, enough to cross the pin sync
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         temperature_high <= 1'b0;
      else
         temperature_high <= heat_cmd;
   end
endmodule : frc_power_stage
`default_nettype wire

//--- testbench/tb.sv
// Purpose: Register level test of the frequency reference combiner
// Assumes: Short ramp tick, ramp times zero except in ramp test
// Notes: Source switch pin high picks the second choice
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic pclk, presetn, psel, penable, pwrite, pin, heat, pready, pslverr, err_q, hot;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic [15:0] main_x, preset_freq;
   frc_pkg::frc_ulim_src_t ulim;
   frc_pkg::frc_drive_t drive;
   int errors = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [15:0] ri [12] = '{frc_pkg::IDX_PRESET, frc_pkg::IDX_DIR, frc_pkg::IDX_MAXF,
      frc_pkg::IDX_ULIM_SEL, frc_pkg::IDX_ULIM, frc_pkg::IDX_ULIM_OFS, frc_pkg::IDX_LLIM,
      frc_pkg::IDX_SWF, frc_pkg::IDX_THERM, frc_pkg::IDX_T_UP, frc_pkg::IDX_T_DN,
      frc_pkg::IDX_SUPERPOS};
   logic [15:0] rv [12] = '{frc_pkg::RST_PRESET, 16'h0000, frc_pkg::RST_MAXF, 16'h0000,
      frc_pkg::RST_ULIM, 16'h0000, 16'h0000, frc_pkg::RST_SWF, frc_pkg::RST_THERM,
      frc_pkg::RST_T_RAMP, frc_pkg::RST_T_RAMP, 16'h0000};
   logic [15:0] ms [11] = '{16'h0000, 16'h0001, 16'h000B, 16'h0015, 16'h001F, 16'h0029,
      16'h0002, 16'h0002, 16'h0003, 16'h0004, 16'h0004};
   logic mp [11] = '{0, 0, 0, 0, 0, 0, 1, 0, 1, 1, 0};
   logic [15:0] me [11] = '{16'h2710, 16'h3E80, 16'h0FA0, 16'h2710, 16'h1770, 16'h1770,
      16'h1770, 16'h2710, 16'h3E80, 16'h3E80, 16'h1770};
   logic [15:0] ue [6] = '{16'h0FA0, 16'h1388, 16'h1770, 16'h1F40, 16'h1770, 16'h1B58};
   frc_combiner #(.TICK_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .main_freq_x(main_x), .aux_freq_y(16'h0000),
      .ulim_src(ulim), .digital_input_terminal(pin), .temperature_high(hot), .drive(drive),
      .preset_freq(preset_freq));
   frc_power_stage u_stage (.pclk(pclk), .presetn(presetn), .drive(drive), .heat_cmd(heat),
      .temperature_high(hot));
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic tally_and_finish;
      if (errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // Hang guard well above the length of the sequence
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [15:0] idx, input logic [15:0] d);
      apb(1'b1, idx, d);
   endtask : wr
   task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
      apb(1'b0, idx, 16'h0000);
      check("register", rd_q, {16'h0000, exp});
   endtask : rd
   function automatic logic [15:0] probe(input int w);
      case (w)
         0: return drive.freq;
         1: return drive.carrier_period;
         2: return {15'h0000, drive.reverse};
         default: return preset_freq;
      endcase
   endfunction : probe
   task automatic await(input string nm, input int w, input logic [15:0] exp);
      int n;
      n = 0;
      // Settle first, so a stale value equal to the new one cannot pass early
      repeat (10) @(posedge pclk);
      while (probe(w) !== exp && n < 60)
      begin
         @(posedge pclk);
         n++;
      end
      check(nm, probe(w), exp);
   endtask : await
   task automatic step(input logic [15:0] exp);
      logic [15:0] old;
      int n;
      old = drive.freq;
      n = 0;
      while (drive.freq === old && n < 40)
      begin
         @(posedge pclk);
         n++;
      end
      check("ramp", drive.freq, exp);
   endtask : step
   initial
   begin
      {presetn, psel, penable, pwrite, pin, heat, paddr, pwdata} = '0;
      main_x = 16'h2710;
      ulim = '{16'h0BB8, 16'h0FA0, 16'h1388, 16'h1770, 16'h1B58};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++)
         rd(ri[i], rv[i]);
      apb(1'b0, 16'h0000, 16'h0000);
      check("unmapped error", err_q, 1'b1);
      check("unmapped data", rd_q, 32'h0000_0000);
      await("carrier", 1, 16'h1A0A);
      wr(frc_pkg::IDX_PRESET, 16'hFFFF);
      await("preset", 3, frc_pkg::FREQ_TOP);
      wr(frc_pkg::IDX_MAXF, 16'hEA60);
      wr(frc_pkg::IDX_ULIM, 16'hEA60);
      wr(frc_pkg::IDX_T_UP, 16'h0000);
      wr(frc_pkg::IDX_T_DN, 16'h0000);
      wr(frc_pkg::IDX_AUX_PCT, 16'h000A);
      wr(frc_pkg::IDX_DI2_FUNC, frc_pkg::DI_FUNC_SWITCH);
      wr(frc_pkg::IDX_CTRL, 16'h0001);
      for (int i = 0; i < 11; i++)
      begin
         pin <= mp[i];
         wr(frc_pkg::IDX_SUPERPOS, ms[i]);
         await("mode", 0, me[i]);
      end
      wr(frc_pkg::IDX_AUX_BASE, 16'h0001);
      wr(frc_pkg::IDX_SUPERPOS, 16'h0001);
      await("aux on main", 0, 16'h2AF8);
      wr(frc_pkg::IDX_AUX_PCT, 16'h00C8);
      rd(frc_pkg::IDX_AUX_PCT, frc_pkg::PCT_TOP);
      pin <= 1'b1;
      wr(frc_pkg::IDX_SUPERPOS, 16'h0002);
      await("aux capped", 0, 16'h3A98);
      pin <= 1'b0;
      wr(frc_pkg::IDX_SUPERPOS, 16'h0063);
      rd(frc_pkg::IDX_SUPERPOS, frc_pkg::SEL_TOP);
      wr(frc_pkg::IDX_SUPERPOS, 16'h0000);
      wr(frc_pkg::IDX_LLIM, 16'h4E20);
      await("lower", 0, 16'h4E20);
      wr(frc_pkg::IDX_ULIM, 16'h1F40);
      await("upper over lower", 0, 16'h1F40);
      wr(frc_pkg::IDX_LLIM, 16'h0000);
      wr(frc_pkg::IDX_ULIM_OFS, 16'h03E8);
      for (int i = 0; i < 6; i++)
      begin
         wr(frc_pkg::IDX_ULIM_SEL, 16'(i + 1));
         await("upper source", 0, ue[i]);
      end
      wr(frc_pkg::IDX_ULIM_SEL, 16'h0000);
      wr(frc_pkg::IDX_ULIM, 16'hEA60);
      wr(frc_pkg::IDX_MAXF, 16'h1388);
      rd(frc_pkg::IDX_MAXF, 16'hEA60);
      @(posedge pclk);
      main_x <= 16'hF000;
      await("maximum", 0, 16'hEA60);
      main_x <= 16'h2710;
      wr(frc_pkg::IDX_DIR, 16'h0001);
      await("reverse", 2, 16'h0001);
      wr(frc_pkg::IDX_SWF, 16'h0096);
      await("carrier top", 1, 16'h0A6A);
      heat <= 1'b1;
      await("carrier hot", 1, 16'h14D5);
      wr(frc_pkg::IDX_THERM, 16'h0000);
      await("carrier fixed", 1, 16'h0A6A);
      heat <= 1'b0;
      wr(frc_pkg::IDX_CTRL, 16'h0000);
      await("stopped", 0, 16'h0000);
      wr(frc_pkg::IDX_T_UNIT, 16'h0002);
      wr(frc_pkg::IDX_T_UP, 16'h0004);
      wr(frc_pkg::IDX_T_DN, 16'h0004);
      wr(frc_pkg::IDX_RAMP_BASE, 16'h0002);
      wr(frc_pkg::IDX_CTRL, 16'h0001);
      for (int k = 1; k < 5; k++)
         step(16'(2500 * k));
      wr(frc_pkg::IDX_CTRL, 16'h0000);
      for (int k = 3; k >= 0; k--)
         step(16'(2500 * k));
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
